/* File: core/adc_sequencing_control.sv */
/*
 * Converter sequencing control: APB register file, rate divider, SAR
 * sequencer, done flag, result lock and low-power handling.
 * Assumes an analog core that samples on sample_hold, compares against
 * trial_code and reports over/under range; APB master per AMBA.
 */
`timescale 1ns/1ps
module adc_sequencing_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] channel_select,
    output logic converter_enable,
    output logic sample_hold,
    output logic [9:0] trial_code,
    input wire logic comp_high,
    input wire logic over_range,
    input wire logic under_range,
    input wire logic halt_mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] control;
    logic done_flag;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_bits;
    logic high_locked;
    logic [7:0] settle_count;
    logic settled;
    logic run;
    logic tick;
    logic sar_done;
    logic [9:0] sar_result;
    logic [1:0] rate;
    logic converter_on;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic hit_low;
    logic hit_high;
    logic hit_control;
    logic mapped;
    logic rd_low;
    logic rd_high;
    logic wr_control;
    logic hold_high;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_low = (paddr == adc_pkg::ADDR_RESULT_LOW);
    assign hit_high = (paddr == adc_pkg::ADDR_RESULT_HIGH);
    assign hit_control = (paddr == adc_pkg::ADDR_CONTROL);
    assign mapped = hit_low | hit_high | hit_control;
    assign rd_low = access & ~pwrite & hit_low;
    assign rd_high = access & ~pwrite & hit_high;
    assign wr_control = access & pwrite & hit_control & pstrb[0];

    // zero wait states; data is captured in setup so it comes from a flop
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (hit_low) begin
                prdata <= {24'h00_0000, result_low_bits};
            end else if (hit_high) begin
                prdata <= {24'h00_0000, result_high_byte};
            end else if (hit_control) begin
                prdata <= {24'h00_0000, done_flag, control[6:0]};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // zero after reset
    // done bit and bit 3 not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= adc_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            control <= pwdata[7:0] & adc_pkg::CONTROL_WR_MASK;
        end
    end

    // channel code straight to the mux
    assign channel_select = control[adc_pkg::CHAN_LSB +: 3];
    assign converter_on = control[adc_pkg::ON_BIT];
    assign rate = {control[adc_pkg::SLOW_BIT], control[adc_pkg::SPEED_BIT]};

    // ------------------------------------------------------------
    // low power
    // ------------------------------------------------------------
    // hold off after halt until the settle count runs out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_count <= 8'h00;
        end else if (halt_mode) begin
            settle_count <= 8'(adc_pkg::WAKE_SETTLE_CYCLES);
        end else if (settle_count != 8'h00) begin
            settle_count <= settle_count - 8'h01;
        end
    end
    assign settled = (settle_count == 8'h00);

    // wait mode has no term here, converter keeps going
    assign run = converter_on & ~halt_mode & settled;
    assign converter_enable = run;

    // ------------------------------------------------------------
    // converter clock and sequencer
    // ------------------------------------------------------------
    // rate is assumed stable while running
    rate_divider u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .rate(rate),
        .tick(tick)
    );

    sar_sequencer u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .tick(tick),
        .comp_high(comp_high),
        .over_range(over_range),
        .under_range(under_range),
        .sample_hold(sample_hold),
        .trial_code(trial_code),
        .done(sar_done),
        .result(sar_result)
    );

    // ------------------------------------------------------------
    // done flag
    // ------------------------------------------------------------
    // set on completion, set wins over a clear
    // cleared by high read or control write
    // the flag is the only completion signal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (sar_done) begin
            done_flag <= 1'b1;
        end else if (rd_high || wr_control) begin
            done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result registers and lock
    // ------------------------------------------------------------
    // low read locks, high read unlocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_locked <= 1'b0;
        end else if (rd_low) begin
            high_locked <= 1'b1;
        end else if (rd_high) begin
            high_locked <= 1'b0;
        end
    end

    // freeze already in the setup cycle of a low read; its access cycle is not held, so a result landing then splits the pair
    assign hold_high = high_locked | (setup & ~pwrite & hit_low);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte <= adc_pkg::RESULT_RESET;
        end else if (sar_done && !hold_high) begin
            result_high_byte <= sar_result[9:2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_low_bits <= adc_pkg::RESULT_RESET;
        end else if (sar_done) begin
            result_low_bits <= {6'h00, sar_result[1:0]};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sat_high_a: assert property (sar_done && $past(over_range) |-> sar_result == adc_pkg::RESULT_MAX)
        else $error("over range did not give full scale");

    sat_low_a: assert property (sar_done && $past(under_range) && !$past(over_range)
        |-> sar_result == adc_pkg::RESULT_MIN)
        else $error("under range did not give zero");

    chan_write_a: assert property (wr_control |=> channel_select == $past(pwdata[2:0]))
        else $error("channel select not taken from write");

    start_conv_a: assert property ($rose(run) |=> sample_hold)
        else $error("conversion did not start");

    stop_conv_a: assert property (!converter_on |=> !sample_hold && !sar_done)
        else $error("conversion kept going while off");

    done_set_a: assert property (sar_done |=> done_flag)
        else $error("done flag not set on completion");

    done_clear_a: assert property ((rd_high || wr_control) && !sar_done |=> !done_flag)
        else $error("done flag not cleared");

    lock_hold_a: assert property (high_locked && !rd_high |=> $stable(result_high_byte))
        else $error("high byte changed while locked");

    rate_quarter_a: assert property (tick && rate == adc_pkg::RATE_DIV4 && $stable(rate)
        |=> !tick ##1 !tick ##1 !tick)
        else $error("quarter rate ticked too often");

    high_map_a: assert property (sar_done && !hold_high |=> result_high_byte == $past(sar_result[9:2]))
        else $error("high byte not result bits 9:2");

    low_zero_a: assert property (result_low_bits[7:2] == 6'h00)
        else $error("low register upper bits not zero");

    done_ro_a: assert property (wr_control && pwdata[7] && !sar_done |=> !done_flag)
        else $error("done flag written by software");

    halt_off_a: assert property ($fell(halt_mode) |-> !converter_enable [*8])
        else $error("converter ran during settle time");

    low_map_a: assert property (sar_done |=> result_low_bits == {6'h00, $past(sar_result[1:0])})
        else $error("low register not result bits 1:0");

    lock_set_a: assert property (rd_low |=> high_locked)
        else $error("low read did not lock high byte");

    lock_free_a: assert property (rd_high |=> !high_locked)
        else $error("high read did not unlock");

    halt_stop_a: assert property (halt_mode |=> !sample_hold && !sar_done)
        else $error("sequencer kept going in halt");

    done_keep_a: assert property (done_flag && !rd_high && !wr_control |=> done_flag)
        else $error("done flag lost without a clear");

    chan_keep_a: assert property (!wr_control |=> $stable(channel_select))
        else $error("channel select changed without a write");

    full_read_c: cover property (rd_low ##[1:20] rd_high);
    saturate_c: cover property (sar_done && $past(over_range));
    wake_run_c: cover property ($fell(halt_mode) ##[1:200] $rose(converter_enable));
    locked_drop_c: cover property (high_locked && sar_done);
endmodule

/* File: common/adc_pkg.sv */
/*
 * Shared constants and types for the converter sequencing control:
 * register indices, field positions, reset values, rate codes and timing.
 * Assumes a 125 MHz register clock and 32-bit APB data.
 */
package adc_pkg;
    // ------------------------------------------------------------
    // register map (index; byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_RESULT_LOW = 8'h6F;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h70;
    localparam logic [7:0] IDX_CONTROL = 8'h71;
    localparam logic [11:0] ADDR_RESULT_LOW = {2'h0, IDX_RESULT_LOW, 2'h0};
    localparam logic [11:0] ADDR_RESULT_HIGH = {2'h0, IDX_RESULT_HIGH, 2'h0};
    localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};

    // ------------------------------------------------------------
    // control/status fields
    // ------------------------------------------------------------
    localparam int DONE_BIT = 7;
    localparam int SPEED_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int SLOW_BIT = 4;
    localparam int CHAN_LSB = 0;
    localparam logic [7:0] CONTROL_WR_MASK = 8'h77;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ------------------------------------------------------------
    // result codes
    // ------------------------------------------------------------
    localparam logic [9:0] RESULT_MAX = 10'h3FF;
    localparam logic [9:0] RESULT_MIN = 10'h000;
    localparam logic [9:0] TRIAL_FIRST = 10'h200;
    localparam logic [3:0] TRIAL_TOP_BIT = 4'h9;

    // ------------------------------------------------------------
    // rate select codes, {slow, speed}
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_FULL = 2'h1;
    localparam logic [1:0] RATE_HALF_F = 2'h3;
    localparam logic [1:0] RATE_DIV2 = 2'h0;
    localparam logic [1:0] RATE_DIV4 = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [1:0] SAMPLE_TICKS = 2'h3;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_SETTLE_NS = 1000;
    localparam int WAKE_SETTLE_CYCLES = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SAR_IDLE = 3'h1,
        SAR_SAMPLE = 3'h2,
        SAR_CONVERT = 3'h4
    } sar_state_t;
endpackage

/* File: core/rate_divider.sv */
/*
 * Converter clock enable from the bus clock, selected by the rate code.
 * Assumes rate is stable while run is high.
 */
`timescale 1ns/1ps
module rate_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] rate,
    output logic tick
);
    logic [1:0] count;

    // counter restarts while stopped, so the first tick is predictable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 2'h0;
        end else if (!run) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    always_comb begin
        case (rate)
            adc_pkg::RATE_FULL: tick = run;
            adc_pkg::RATE_HALF_F: tick = run & count[0];
            adc_pkg::RATE_DIV2: tick = run & count[0];
            adc_pkg::RATE_DIV4: tick = run & (count == 2'h3);
            default: tick = 1'b0;
        endcase
    end
endmodule

/* File: core/sar_sequencer.sv */
/*
 * Successive approximation sequencer: sample, ten bit trials, repeat.
 * Assumes comp_high is the analog comparator (input at or above trial).
 */
`timescale 1ns/1ps
module sar_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic tick,
    input wire logic comp_high,
    input wire logic over_range,
    input wire logic under_range,
    output logic sample_hold,
    output logic [9:0] trial_code,
    output logic done,
    output logic [9:0] result
);
    adc_pkg::sar_state_t state;
    logic [1:0] sample_count;
    logic [3:0] bit_idx;
    logic [9:0] next_code;

    always_comb begin
        next_code = trial_code;
        next_code[bit_idx] = comp_high;
        if (bit_idx != 4'h0) begin
            next_code[bit_idx - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= adc_pkg::SAR_IDLE;
            sample_count <= 2'h0;
            bit_idx <= 4'h0;
            trial_code <= adc_pkg::RESULT_MIN;
            done <= 1'b0;
            result <= adc_pkg::RESULT_MIN;
        end else begin
            done <= 1'b0;
            // stop at once, partial result dropped
            if (!run) begin
                state <= adc_pkg::SAR_IDLE;
            end else begin
                case (state)
                    adc_pkg::SAR_IDLE: begin
                        state <= adc_pkg::SAR_SAMPLE;
                        sample_count <= 2'h0;
                    end
                    adc_pkg::SAR_SAMPLE: begin
                        if (tick) begin
                            sample_count <= sample_count + 2'h1;
                            if (sample_count == adc_pkg::SAMPLE_TICKS - 2'h1) begin
                                state <= adc_pkg::SAR_CONVERT;
                                trial_code <= adc_pkg::TRIAL_FIRST;
                                bit_idx <= adc_pkg::TRIAL_TOP_BIT;
                            end
                        end
                    end
                    adc_pkg::SAR_CONVERT: begin
                        if (tick) begin
                            trial_code <= next_code;
                            bit_idx <= bit_idx - 4'h1;
                            if (bit_idx == 4'h0) begin
                                if (over_range) begin
                                    result <= adc_pkg::RESULT_MAX;
                                end else if (under_range) begin
                                    result <= adc_pkg::RESULT_MIN;
                                end else begin
                                    result <= next_code;
                                end
                                done <= 1'b1;
                                state <= adc_pkg::SAR_SAMPLE;
                                sample_count <= 2'h0;
                            end
                        end
                    end
                    default: state <= adc_pkg::SAR_IDLE;
                endcase
            end
        end
    end

    assign sample_hold = (state == adc_pkg::SAR_SAMPLE);
endmodule

/* File: sim/analog_core_model.sv */
/*
 * Behavioural analog core: input mux, sample and hold, comparator and
 * range detectors facing the sequencing control.
 * Assumes levels holds 12 bits per channel: {over, under, code}.
 */
`timescale 1ns/1ps
module analog_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] channel_select,
    input wire logic converter_enable,
    input wire logic sample_hold,
    input wire logic [9:0] trial_code,
    input wire logic [71:0] levels,
    output logic comp_high,
    output logic over_range,
    output logic under_range
);
    // ------------------------------------------------------------
    // sample and compare
    // ------------------------------------------------------------
    logic [11:0] held;
    logic toggle;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 12'h000;
        end else if (sample_hold) begin
            held <= (channel_select < 3'h6) ? levels[channel_select * 12 +: 12] : 12'h000;
        end
    end
    // powered down: outputs wander, so no stale level is trusted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
        end
    end
    assign comp_high = converter_enable ? (held[11] | (!held[10] & (held[9:0] >= trial_code))) : toggle;
    assign over_range = converter_enable ? held[11] : toggle;
    assign under_range = converter_enable ? held[10] : ~toggle;
endmodule

/* File: sim/adc_sequencing_control_tb.sv */
/*
 * Self-checking bench for the converter sequencing control.
 * Assumes the analog core model on the far side; APB master in here.
 */
`timescale 1ns/1ps
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module adc_sequencing_control_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, halt_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, converter_enable, sample_hold, comp_high, over_range, under_range;
    logic [2:0] channel_select;
    logic [9:0] trial_code;
    logic [71:0] lv;
    logic [33:0] q[$];
    int error_cnt, cmp_count;

    adc_sequencing_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .channel_select(channel_select),
        .converter_enable(converter_enable), .sample_hold(sample_hold), .trial_code(trial_code),
        .comp_high(comp_high), .over_range(over_range), .under_range(under_range), .halt_mode(halt_mode));
    analog_core_model u_core (.pclk(pclk), .presetn(presetn), .channel_select(channel_select),
        .converter_enable(converter_enable), .sample_hold(sample_hold), .trial_code(trial_code),
        .levels(lv), .comp_high(comp_high), .over_range(over_range), .under_range(under_range));

    always #(adc_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic ran_out();
        error_cnt++;
        $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        finish_test();
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [33:0] e,
        output logic [7:0] rd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        if (!w) begin
            q.push_back(e);
        end
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) ran_out();
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] rd;
        apb(a, 1'b1, d, 34'h0, rd);
    endtask
    task automatic rdc(input logic [11:0] a, input logic err, input logic [7:0] e);
        logic [7:0] rd;
        apb(a, 1'b0, 8'h00, {1'b1, err, 24'h000000, e}, rd);
    endtask
    task automatic rdr(input logic [11:0] a, output logic [7:0] rd);
        apb(a, 1'b0, 8'h00, 34'h0, rd);
    endtask
    task automatic wait_done();
        logic [7:0] v;
        int i;
        v = 8'h00;
        for (i = 0; i < 100 && v[7] !== 1'b1; i++) rdr(adc_pkg::ADDR_CONTROL, v);
        if (v[7] !== 1'b1) ran_out();
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic check_zero();
        rdc(adc_pkg::ADDR_RESULT_LOW, 1'b0, 8'h00);
        rdc(adc_pkg::ADDR_RESULT_HIGH, 1'b0, 8'h00);
        rdc(adc_pkg::ADDR_CONTROL, 1'b0, 8'h00);
    endtask

    // ------------------------------------------------------------
    // monitor: oldest note against each read answer
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        logic [33:0] e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            if (e[33]) `CHECK({pslverr, prdata}, e[32:0])
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int r, i, n, ch;
        logic [9:0] v, b;
        logic [7:0] rd;
        logic [9:0] t;
        int per[4];
        per = '{2, 1, 4, 2};
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; halt_mode = 1'b0;
        paddr = 12'h000; pwdata = 32'h00000000; pstrb = 4'h1; lv = 72'h0;
        error_cnt = 0; cmp_count = 0;
        void'($urandom(46051));
        do_reset();
        check_zero();
        rdc(12'h000, 1'b1, 8'h00);
        wr(adc_pkg::ADDR_CONTROL, 8'hFF);
        rdc(adc_pkg::ADDR_CONTROL, 1'b0, 8'h77);
        `CHECK(channel_select, 3'h7)
        wr(adc_pkg::ADDR_CONTROL, 8'h00);
        // write with its byte strobe off is ignored
        pstrb <= 4'h0;
        wr(adc_pkg::ADDR_CONTROL, 8'h25);
        pstrb <= 4'h1;
        rdc(adc_pkg::ADDR_CONTROL, 1'b0, 8'h00);
        // tick period per rate code, rate set before on
        for (r = 0; r < 4; r++) begin
            wr(adc_pkg::ADDR_CONTROL, {1'b0, r[0], 1'b0, r[1], 4'h0});
            wr(adc_pkg::ADDR_CONTROL, {1'b0, r[0], 1'b1, r[1], 4'h0});
            for (n = 0; n < 40 && sample_hold !== 1'b1; n++) @(posedge pclk);
            if (n == 40) ran_out();
            for (n = 0; n < 80 && sample_hold !== 1'b0; n++) begin
                @(posedge pclk);
                #1;
            end
            if (n == 80) ran_out();
            t = trial_code;
            for (n = 0; n < 20 && trial_code === t; n++) begin
                @(posedge pclk);
                #1;
            end
            `CHECK(n, per[r])
            wr(adc_pkg::ADDR_CONTROL, 8'h00);
        end
        // divided rate; saturation in the last two runs
        for (i = 0; i < 8; i++) begin
            ch = i % 6;
            v = 10'($urandom);
            lv[ch * 12 +: 12] <= {i == 6, i == 7, v};
            v = (i == 6) ? 10'h3FF : (i == 7) ? 10'h000 : v;
            wr(adc_pkg::ADDR_CONTROL, 8'h20 | 8'(ch));
            // control flop settles after the access edge
            #1;
            `CHECK(channel_select, 3'(ch))
            wait_done();
            rdc(adc_pkg::ADDR_RESULT_LOW, 1'b0, {6'h00, v[1:0]});
            rdc(adc_pkg::ADDR_RESULT_HIGH, 1'b0, v[9:2]);
            wr(adc_pkg::ADDR_CONTROL, 8'h00);
        end
        v = 10'($urandom);
        b = ~v;
        lv[12 +: 12] <= {2'b00, v};
        wr(adc_pkg::ADDR_CONTROL, 8'h21);
        wait_done();
        rdc(adc_pkg::ADDR_RESULT_LOW, 1'b0, {6'h00, v[1:0]});
        lv[12 +: 12] <= {2'b00, b};
        repeat (80) @(posedge pclk);
        rdc(adc_pkg::ADDR_RESULT_HIGH, 1'b0, v[9:2]);
        repeat (80) @(posedge pclk);
        rdc(adc_pkg::ADDR_RESULT_HIGH, 1'b0, b[9:2]);
        rdc(adc_pkg::ADDR_RESULT_LOW, 1'b0, {6'h00, b[1:0]});
        // high read clears done; control write stops and clears
        wr(adc_pkg::ADDR_CONTROL, 8'h11);
        wr(adc_pkg::ADDR_CONTROL, 8'h31);
        wait_done();
        rdr(adc_pkg::ADDR_RESULT_HIGH, rd);
        rdc(adc_pkg::ADDR_CONTROL, 1'b0, 8'h31);
        wait_done();
        wr(adc_pkg::ADDR_CONTROL, 8'h11);
        repeat (120) @(posedge pclk);
        rdc(adc_pkg::ADDR_CONTROL, 1'b0, 8'h11);
        `CHECK(converter_enable, 1'b0)
        `CHECK(sample_hold, 1'b0)
        wr(adc_pkg::ADDR_CONTROL, 8'h21);
        halt_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHECK(converter_enable, 1'b0)
        halt_mode <= 1'b0;
        repeat (120) @(posedge pclk);
        `CHECK(converter_enable, 1'b0)
        repeat (15) @(posedge pclk);
        `CHECK(converter_enable, 1'b1)
        wait_done();
        do_reset();
        check_zero();
        finish_test();
    end
endmodule
